// ==== rtl/core_interrupt_unit.sv ====
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ciu_defs.svh"

module ciu_core_interrupt_unit (
	input  wire logic                    core_clk_in,        // 100 MHz core clock
	input  wire logic                    sys_rst_in,         // Synchronous device reset, high
	input  wire ciu_pkg::ciu_rst_cause_t rst_cause_in,       // Kind of the current reset
	input  wire logic                    wb_cyc_in,          // Wishbone cycle
	input  wire logic                    wb_stb_in,          // Wishbone strobe
	input  wire logic                    wb_we_in,           // Wishbone write enable
	input  wire logic [4:0]              wb_adr_in,          // Wishbone byte address
	input  wire logic [3:0]              wb_sel_in,          // Wishbone byte selects
	input  wire logic [31:0]             wb_dat_in,          // Wishbone write data
	output logic      [31:0]             wb_dat_out,         // Wishbone read data
	output logic                         wb_ack_out,         // Wishbone acknowledge
	input  wire logic [15:0]             event_in,           // Synchronous source event pulses
	input  wire logic                    ext_pin_in,         // External edge pin, asynchronous
	input  wire logic                    sleep_in,           // Core is asleep
	input  wire logic                    return_from_isr_in, // Core executes return from handler
	input  wire ciu_pkg::ciu_retire_t    retire_in,          // Retired instruction flag report
	output ciu_pkg::ciu_core_ctl_t       core_ctl_out,       // Sequencer pulses to the core
	output logic      [12:0]             pc_vector_out,      // Address loaded on pc_load
	output logic      [1:0]              q_phase_out,        // Current instruction phase
	output logic      [7:0]              status_flags_out    // Core status register
);

	// Source index map shared by enables, flags and wake logic
	localparam int SRC_PORT   = 0;
	localparam int SRC_EXT    = 1;
	localparam int SRC_TIMER0 = 2;
	localparam int SRC_P1     = 3;
	localparam int SRC_P2     = 11;

	logic [7:0]          irq_control_reg;
	logic [7:0]          periph_enable_reg_1;
	logic [4:0]          periph_enable_reg_2;
	logic [7:0]          periph_flag_reg_1;
	logic [4:0]          periph_flag_reg_2;
	logic [7:0]          option_reg;
	logic [1:0]          power_control_reset_cause;
	logic [7:0]          core_status_flags;
	logic [3:0]          q_cnt_reg;
	logic [1:0]          q_phase_reg;
	logic                q_tick;
	logic                tcy_tick;
	logic                pin_meta_reg;
	logic                pin_sync_reg;
	logic                pin_prev_reg;
	logic                ext_edge;
	logic [15:0]         src_enable;
	logic [15:0]         src_flag;
	logic [15:0]         src_event;
	logic [15:0]         src_ready;
	logic                take_req;
	logic                wake_req;
	logic                bus_req;
	logic                wr_stb;
	logic [2:0]          wr_index;
	logic [7:0]          wr_byte;
	logic [7:0]          rd_byte;
	ciu_pkg::ciu_state_t state_reg;
	ciu_pkg::ciu_state_t state_next;

	// Map a byte address to a register index; the byte-lane bits below the word index are ignored
	function automatic logic [2:0] reg_index(input logic [4:0] adr);
		reg_index = adr[4:2];
	endfunction

	// Is a given register being written this cycle
	function automatic logic reg_wr(input logic stb, input logic [2:0] idx, input logic [4:0] ofs);
		reg_wr = stb && (idx == reg_index(ofs));
	endfunction

	// Bus request decode; ack is registered so a classic master sees one wait state
	assign bus_req  = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_stb   = bus_req && wb_we_in && wb_sel_in[0];
	assign wr_index = reg_index(wb_adr_in);
	assign wr_byte  = wb_dat_in[7:0];

	// Acknowledge every access, mapped or not, one cycle after the strobe
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			wb_ack_out <= 1'b0;
		else
			wb_ack_out <= bus_req;
	end

	// Read mux, narrow registers sit in the low bits
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (wr_index)
			reg_index(`CIU_OFS_IRQ_CONTROL):   rd_byte = irq_control_reg;
			reg_index(`CIU_OFS_PERIPH_EN_1):   rd_byte = periph_enable_reg_1;
			reg_index(`CIU_OFS_PERIPH_EN_2):   rd_byte = {3'h0, periph_enable_reg_2};
			reg_index(`CIU_OFS_PERIPH_FLAG_1): rd_byte = periph_flag_reg_1;
			reg_index(`CIU_OFS_PERIPH_FLAG_2): rd_byte = {3'h0, periph_flag_reg_2};
			reg_index(`CIU_OFS_OPTION):        rd_byte = option_reg;
			reg_index(`CIU_OFS_POWER_CONTROL): rd_byte = {6'h00, power_control_reset_cause};
			reg_index(`CIU_OFS_STATUS_FLAGS):  rd_byte = core_status_flags;
		endcase
	end

	// Read data captured with the request so it stands with ack
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			wb_dat_out <= 32'h0000_0000;
		else if (bus_req && !wb_we_in)
			wb_dat_out <= {24'h00_0000, rd_byte};
	end

	// Quarter-phase divider; one enable pulse per phase, wrap marks the first phase
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			q_cnt_reg   <= 4'h0;
			q_phase_reg <= 2'h0;
		end
		else if (q_tick)
		begin
			q_cnt_reg   <= 4'h0;
			q_phase_reg <= q_phase_reg + 2'h1;
		end
		else
			q_cnt_reg <= q_cnt_reg + 4'h1;
	end

	assign q_tick      = (q_cnt_reg == 4'(`CIU_Q_CLKS - 1));
	assign tcy_tick    = q_tick && (q_phase_reg == 2'h3);
	assign q_phase_out = q_phase_reg;

	// Pin synchroniser; the pin is asynchronous so its edge lands in an arbitrary phase.
	// It runs through reset so the edge detector leaves reset at the pin's real level;
	// a fixed reset value would fake an edge whenever the pin idles at the other level.
	always_ff @(posedge core_clk_in)
	begin
		pin_meta_reg <= ext_pin_in;
		pin_sync_reg <= pin_meta_reg;
		pin_prev_reg <= pin_sync_reg;
	end

	// Edge select picks rising or falling edges
	assign ext_edge = option_reg[`CIU_OPT_EDGE_SEL] ? (pin_sync_reg && !pin_prev_reg)
	                                                : (!pin_sync_reg && pin_prev_reg);

	// Gather events; pin edge replaces any synchronous event at its index
	always_comb
	begin
		src_event          = event_in;
		src_event[SRC_EXT] = ext_edge;
	end

	// Gather enables and flags into source order
	assign src_enable = {periph_enable_reg_2, periph_enable_reg_1,
	                     irq_control_reg[`CIU_IC_TIMER0_EN], irq_control_reg[`CIU_IC_EXT_EN],
	                     irq_control_reg[`CIU_IC_PORT_EN]};
	assign src_flag   = {periph_flag_reg_2, periph_flag_reg_1,
	                     irq_control_reg[`CIU_IC_TIMER0_FLAG], irq_control_reg[`CIU_IC_EXT_FLAG],
	                     irq_control_reg[`CIU_IC_PORT_FLAG]};

	// Per-source readiness; peripheral sources also need the group enable
	genvar g;
	generate
		for (g = 0; g < `CIU_NUM_SOURCES; g++)
		begin : g_src
			if (g < SRC_P1)
			begin : g_core
				assign src_ready[g] = src_flag[g] && src_enable[g];
			end
			else
			begin : g_periph
				assign src_ready[g] = src_flag[g] && src_enable[g]
				                      && irq_control_reg[`CIU_IC_GROUP_EN];
			end
		end
	endgenerate

	// Only sources that run without the system clock may wake the core
	assign wake_req = sleep_in && |(src_ready & `CIU_WAKE_CAPABLE);

	// Request taken in the last phase of each cycle; a disabled global enable just leaves the flag waiting
	assign take_req = tcy_tick && !sleep_in && irq_control_reg[`CIU_IC_GLOBAL_EN]
	                  && |src_ready;

	// Sequencer: one step per instruction cycle except the move from idle into wake execution, never waits for the current instruction
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ciu_pkg::CIU_IDLE:
			begin
				if (wake_req && irq_control_reg[`CIU_IC_GLOBAL_EN])
					state_next = ciu_pkg::CIU_WAKE_EXEC;
				else if (take_req)
					state_next = ciu_pkg::CIU_FLUSH;
			end
			ciu_pkg::CIU_WAKE_EXEC:
				if (tcy_tick && !sleep_in)
					state_next = ciu_pkg::CIU_FLUSH;
			ciu_pkg::CIU_FLUSH:
				if (tcy_tick)
					state_next = ciu_pkg::CIU_PUSH;
			ciu_pkg::CIU_PUSH:
				if (tcy_tick)
					state_next = ciu_pkg::CIU_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			state_reg <= ciu_pkg::CIU_IDLE;
		else
			state_reg <= state_next;
	end

	// Pulses to the core, registered; only the return address is saved by hardware
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			core_ctl_out <= '0;
		else
		begin
			core_ctl_out.flush_prefetch <= (state_reg != ciu_pkg::CIU_FLUSH)
			                               && (state_next == ciu_pkg::CIU_FLUSH);
			core_ctl_out.push_pc        <= (state_reg == ciu_pkg::CIU_FLUSH)
			                               && (state_next == ciu_pkg::CIU_PUSH);
			core_ctl_out.pc_load        <= (state_reg == ciu_pkg::CIU_FLUSH)
			                               && (state_next == ciu_pkg::CIU_PUSH);
			core_ctl_out.vector_exec    <= (state_reg == ciu_pkg::CIU_PUSH)
			                               && (state_next == ciu_pkg::CIU_IDLE);
			core_ctl_out.pop_pc         <= return_from_isr_in;
			core_ctl_out.wake           <= wake_req && !core_ctl_out.wake;
		end
	end

	// Full vector address; all 13 bits, high part included, are reloaded from the constant every cycle out of reset
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			pc_vector_out <= 13'h0000;
		else
			pc_vector_out <= `CIU_VECTOR_ADDR;
	end

	// Control register: software write, then events set flags, then sequencer owns global enable
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			irq_control_reg <= `CIU_RST_IRQ_CONTROL;
		else
		begin
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_IRQ_CONTROL))
				irq_control_reg <= wr_byte
				                   | {5'h00, src_event[SRC_TIMER0], src_event[SRC_EXT],
				                      src_event[SRC_PORT]};
			else
				irq_control_reg[2:0] <= irq_control_reg[2:0]
				                        | {src_event[SRC_TIMER0], src_event[SRC_EXT],
				                           src_event[SRC_PORT]};
			// Hardware control of the global enable outranks a concurrent software write
			if ((state_reg != ciu_pkg::CIU_FLUSH) && (state_next == ciu_pkg::CIU_FLUSH))
				irq_control_reg[`CIU_IC_GLOBAL_EN] <= 1'b0;
			else if (return_from_isr_in)
				irq_control_reg[`CIU_IC_GLOBAL_EN] <= 1'b1;
		end
	end

	// Peripheral enable registers
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			periph_enable_reg_1 <= `CIU_RST_PERIPH_EN;
			periph_enable_reg_2 <= 5'(`CIU_RST_PERIPH_EN);
		end
		else
		begin
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_PERIPH_EN_1))
				periph_enable_reg_1 <= wr_byte;
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_PERIPH_EN_2))
				periph_enable_reg_2 <= wr_byte[4:0];
		end
	end

	// Peripheral flags: written value ORed with events so a same-cycle event is kept
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			periph_flag_reg_1 <= `CIU_RST_PERIPH_FLAG;
			periph_flag_reg_2 <= 5'(`CIU_RST_PERIPH_FLAG);
		end
		else
		begin
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_PERIPH_FLAG_1))
				periph_flag_reg_1 <= wr_byte | src_event[SRC_P2-1:SRC_P1];
			else
				periph_flag_reg_1 <= periph_flag_reg_1 | src_event[SRC_P2-1:SRC_P1];
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_PERIPH_FLAG_2))
				periph_flag_reg_2 <= wr_byte[4:0] | src_event[15:SRC_P2];
			else
				periph_flag_reg_2 <= periph_flag_reg_2 | src_event[15:SRC_P2];
		end
	end

	// Option register holds the edge select
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			option_reg <= `CIU_RST_OPTION;
		else if (reg_wr(wr_stb, wr_index, `CIU_OFS_OPTION))
			option_reg <= wr_byte;
	end

	// Reset cause: brown-out clears bit 0, other resets leave it; software sets bits back
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			if (rst_cause_in.power_on)
				power_control_reset_cause[`CIU_PC_POR] <= 1'b0;
			if (rst_cause_in.brownout)
				power_control_reset_cause[`CIU_PC_BOR] <= 1'b0;
		end
		else if (reg_wr(wr_stb, wr_index, `CIU_OFS_POWER_CONTROL))
			power_control_reset_cause <= wr_byte[1:0];
	end

	// Status flags: arithmetic flags follow retired instructions, except the nibble swap move
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			core_status_flags <= `CIU_RST_STATUS;
		else
		begin
			if (reg_wr(wr_stb, wr_index, `CIU_OFS_STATUS_FLAGS))
			begin
				core_status_flags[7:5] <= wr_byte[7:5];
				core_status_flags[2:0] <= wr_byte[2:0];
			end
			else if (retire_in.retire && !retire_in.nibble_swap_move)
				core_status_flags[2:0] <= retire_in.alu_flags;
			if (core_ctl_out.wake)
				core_status_flags[`CIU_ST_POWERDOWN] <= 1'b0;
		end
	end

	assign status_flags_out = core_status_flags;

endmodule

// ==== rtl/ciu_defs.svh ====
`ifndef CIU_DEFS_SVH
`define CIU_DEFS_SVH

// Register word offsets (byte addresses on the Wishbone bus)
`define CIU_OFS_IRQ_CONTROL     5'h00
`define CIU_OFS_PERIPH_EN_1     5'h04
`define CIU_OFS_PERIPH_EN_2     5'h08
`define CIU_OFS_PERIPH_FLAG_1   5'h0C
`define CIU_OFS_PERIPH_FLAG_2   5'h10
`define CIU_OFS_OPTION          5'h14
`define CIU_OFS_POWER_CONTROL   5'h18
`define CIU_OFS_STATUS_FLAGS    5'h1C

// Control register field positions
`define CIU_IC_GLOBAL_EN        7
`define CIU_IC_GROUP_EN         6
`define CIU_IC_TIMER0_EN        5
`define CIU_IC_EXT_EN           4
`define CIU_IC_PORT_EN          3
`define CIU_IC_TIMER0_FLAG      2
`define CIU_IC_EXT_FLAG         1
`define CIU_IC_PORT_FLAG        0

// Option register, status register and power control fields
`define CIU_OPT_EDGE_SEL        6
`define CIU_ST_TIMEOUT          4
`define CIU_ST_POWERDOWN        3
`define CIU_PC_POR              1
`define CIU_PC_BOR              0

// Reset values
`define CIU_RST_IRQ_CONTROL     8'h00
`define CIU_RST_PERIPH_EN       8'h00
`define CIU_RST_PERIPH_FLAG     8'h00
`define CIU_RST_OPTION          8'hFF
`define CIU_RST_STATUS          8'h18

// Source count, vector, wake-capable sources, phase timing
`define CIU_NUM_SOURCES         16
`define CIU_VECTOR_ADDR         13'h0004
`define CIU_WAKE_CAPABLE        16'h0003
`define CIU_CLK_MHZ             100
`define CIU_Q_PHASE_NS          10
`define CIU_Q_CLKS              ((`CIU_Q_PHASE_NS * `CIU_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/ciu_pkg.sv ====
package ciu_pkg;

	// Vectoring sequencer, one state per instruction cycle
	typedef enum logic [1:0] {
		CIU_IDLE      = 2'b00,
		CIU_FLUSH     = 2'b01,
		CIU_PUSH      = 2'b10,
		CIU_WAKE_EXEC = 2'b11
	} ciu_state_t;

	// Requests from the unit to the processor core, all one-cycle pulses
	typedef struct packed {
		logic flush_prefetch;
		logic push_pc;
		logic pc_load;
		logic vector_exec;
		logic pop_pc;
		logic wake;
	} ciu_core_ctl_t;

	// Cause of the current device reset
	typedef struct packed {
		logic power_on;
		logic brownout;
	} ciu_rst_cause_t;

	// Instruction retire report from the core for status flag update
	typedef struct packed {
		logic       retire;
		logic       nibble_swap_move;
		logic [2:0] alu_flags;
	} ciu_retire_t;

endpackage

// ==== sim/ciu_checker.sv ====
`timescale 1ns/1ps
module ciu_checker (
	input  wire logic                   core_clk_in,        // Core clock
	input  wire logic                   sys_rst_in,         // Reset
	input  wire logic                   wb_cyc_in,          // Bus cycle
	input  wire logic                   wb_stb_in,          // Bus strobe
	input  wire logic                   wb_ack_out,         // Bus ack
	input  wire logic                   sleep_in,           // Core asleep
	input  wire logic                   return_from_isr_in, // Return pulse
	input  wire ciu_pkg::ciu_retire_t   retire_in,          // Retire report
	input  wire ciu_pkg::ciu_core_ctl_t core_ctl_out,       // Core pulses
	input  wire logic [12:0]            pc_vector_out,      // Vector address
	input  wire logic [1:0]             q_phase_out,        // Phase
	input  wire logic [7:0]             status_flags_out    // Status
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// Reset must silence the core pulses even while it is held
	chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=> core_ctl_out == 6'h00)
		else $error("core pulse after reset");
	// Vectoring steps are tied to fixed instruction-cycle spacing
	chk_flush_push: assert property (core_ctl_out.flush_prefetch |-> ##4
		(core_ctl_out.push_pc && core_ctl_out.pc_load))
		else $error("push not four clocks after flush");
	chk_push_exec: assert property (core_ctl_out.push_pc |=> !core_ctl_out.flush_prefetch [*3]
		##1 core_ctl_out.vector_exec)
		else $error("vector execution late or early");
	chk_vector_addr: assert property (core_ctl_out.pc_load |-> pc_vector_out == 13'h0004)
		else $error("wrong vector address");
	// Flush stands in the first phase of a cycle, whatever the instruction length
	chk_flush_phase: assert property (core_ctl_out.flush_prefetch |-> q_phase_out == 2'h0)
		else $error("flush off the cycle boundary");
	chk_flush_awake: assert property (core_ctl_out.flush_prefetch |-> !$past(sleep_in))
		else $error("flush while still asleep");
	chk_pop_return: assert property (return_from_isr_in |=> core_ctl_out.pop_pc)
		else $error("no pop after return");
	chk_wake_sleep: assert property (core_ctl_out.wake |-> $past(sleep_in))
		else $error("wake without sleep");
	chk_swap_keeps: assert property (retire_in.retire && retire_in.nibble_swap_move |=>
		$stable(status_flags_out[2:0]))
		else $error("swap changed status flags");
	// Bus answer is a single prompt pulse
	chk_ack_prompt: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
endmodule

bind ciu_core_interrupt_unit ciu_checker u_chk (
	.core_clk_in        (core_clk_in),
	.sys_rst_in         (sys_rst_in),
	.wb_cyc_in          (wb_cyc_in),
	.wb_stb_in          (wb_stb_in),
	.wb_ack_out         (wb_ack_out),
	.sleep_in           (sleep_in),
	.return_from_isr_in (return_from_isr_in),
	.retire_in          (retire_in),
	.core_ctl_out       (core_ctl_out),
	.pc_vector_out      (pc_vector_out),
	.q_phase_out        (q_phase_out),
	.status_flags_out   (status_flags_out)
);

// ==== sim/ciu_core_model.sv ====
`timescale 1ns/1ps
module ciu_core_model (
	input  wire logic                   core_clk_in,        // Core clock
	input  wire logic                   sys_rst_in,         // Reset
	input  wire ciu_pkg::ciu_core_ctl_t core_ctl_in,        // Pulses from the unit
	input  wire logic                   ret_en_in,          // Handler returns alone
	input  wire logic [7:0]             ret_dly_in,         // Handler length
	output logic                        return_from_isr_out // Return pulse
);
	logic [7:0] left_reg;

	// Handler runs a span then returns; only the PC was saved, nothing else restored
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			left_reg            <= 8'h00;
			return_from_isr_out <= 1'b0;
		end
		else if (core_ctl_in.vector_exec)
		begin
			left_reg            <= ret_en_in ? ret_dly_in : 8'h00;
			return_from_isr_out <= 1'b0;
		end
		else
		begin
			left_reg            <= (left_reg != 8'h00) ? left_reg - 8'h01 : 8'h00;
			return_from_isr_out <= (left_reg == 8'h01);
		end
	end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic                    clk, rst, cyc, stb, we, pin, slp, ack, ret, ren;
	logic [4:0]              adr;
	logic [3:0]              sel;
	logic [31:0]             wd, rdw;
	logic [15:0]             ev;
	logic [7:0]              r;
	ciu_pkg::ciu_rst_cause_t cause;
	ciu_pkg::ciu_retire_t    rt;
	ciu_pkg::ciu_core_ctl_t  ctl;
	int                      fails, checks, nf, nw, np, n, b, w;

	// Core clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	ciu_core_interrupt_unit dut (
		.core_clk_in(clk), .sys_rst_in(rst), .rst_cause_in(cause),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rdw), .wb_ack_out(ack),
		.event_in(ev), .ext_pin_in(pin), .sleep_in(slp), .return_from_isr_in(ret),
		.retire_in(rt), .core_ctl_out(ctl), .pc_vector_out(), .q_phase_out(),
		.status_flags_out()
	);
	ciu_core_model u_core (
		.core_clk_in(clk), .sys_rst_in(rst), .core_ctl_in(ctl),
		.ret_en_in(ren), .ret_dly_in(8'h06), .return_from_isr_out(ret)
	);

	// Tally core pulses
	always @(posedge clk)
	begin
		nf += (ctl.flush_prefetch === 1'b1);
		nw += (ctl.wake === 1'b1);
		np += (ctl.pop_pc === 1'b1);
	end

	task automatic stop_test;
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single bus cycle, held until ack is seen at an edge
	task automatic acc(input logic wr_en, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr_en;
		adr <= a;
		sel <= s;
		wd <= {24'h000000, d};
		do
		begin
			@(posedge clk);
			k++;
		end
		while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1)
		begin
			fails++;
			stop_test();
		end
		r = rdw[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 4'hF);
	endtask

	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 4'hF);
		chk(r, e);
	endtask

	task automatic pulse(input logic [15:0] v);
		ev <= v;
		@(posedge clk);
		ev <= 16'h0000;
	endtask

	// Bounded wait for a flush count
	task automatic wflush(input int t);
		for (int k = 0; k < 40 && nf < t; k++)
			@(posedge clk);
		chk(nf, t);
		if (nf < t)
			stop_test();
	endtask

	// Clocks until vector execution, bounded
	task automatic lat(input int lo, input int hi);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ctl.vector_exec !== 1'b1 && n < 40);
		chk(n >= lo && n <= hi, 1'b1);
		if (n >= 40)
			stop_test();
	endtask

	task automatic rpulse(input logic [1:0] c);
		rst <= 1'b1;
		cause <= c;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cause <= 2'h0;
		@(posedge clk);
	endtask

	initial
	begin
		{cyc, stb, we, pin, slp, ren} = 6'h00;
		{adr, sel, wd, ev, rt} = 62'h0;
		rst = 1'b1;
		cause = 2'h2;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cause <= 2'h0;
		@(posedge clk);
		rc(5'h00, 8'h00);
		rc(5'h14, 8'hFF);
		rc(5'h1C, 8'h18);
		// Flags latch with every enable clear
		pulse(16'hFFFD);
		rc(5'h00, 8'h05);
		rc(5'h0C, 8'hFF);
		rc(5'h10, 8'h1F);
		wr(5'h0C, 8'h00);
		wr(5'h10, 8'h00);
		// Group gating, then a held request served once enabled
		wr(5'h04, 8'h01);
		wr(5'h00, 8'h80);
		pulse(16'h0008);
		repeat (20) @(posedge clk);
		chk(nf, 0);
		wr(5'h00, 8'h40);
		repeat (20) @(posedge clk);
		chk(nf, 0);
		wr(5'h00, 8'hC0);
		wflush(1);
		rc(5'h00, 8'h40);
		ren <= 1'b1;
		wflush(2);
		chk(np, 1);
		ren <= 1'b0;
		repeat (20) @(posedge clk);
		wr(5'h0C, 8'h00);
		wr(5'h04, 8'h00);
		// Synchronous latency at each phase offset
		for (int i = 0; i < 4; i++)
		begin
			wr(5'h00, 8'hA0);
			repeat (i) @(posedge clk);
			pulse(16'h0004);
			lat(10, 13);
		end
		// Set by event wins over clear in the same cycle
		fork
			wr(5'h00, 8'h00);
			pulse(16'h0004);
		join
		rc(5'h00, 8'h04);
		// Pin edges of both polarities
		for (int e = 0; e < 2; e++)
		begin
			wr(5'h14, e ? 8'hFF : 8'hBF);
			pin <= e[0];
			repeat (8) @(posedge clk);
			wr(5'h00, 8'h00);
			pin <= !e[0];
			repeat (8) @(posedge clk);
			rc(5'h00, 8'h00);
			pin <= e[0];
			repeat (8) @(posedge clk);
			rc(5'h00, 8'h02);
			wr(5'h00, 8'h90);
			pin <= !e[0];
			repeat (8) @(posedge clk);
			pin <= e[0];
			lat(13, 16);
		end
		// Sleep: only capable sources wake, vector waits for the next instruction
		wr(5'h00, 8'h28);
		slp <= 1'b1;
		b = nf;
		pulse(16'h0004);
		repeat (20) @(posedge clk);
		chk(nw, 0);
		pulse(16'h0001);
		repeat (20) @(posedge clk);
		chk(nw != 0, 1'b1);
		chk(nf, b);
		slp <= 1'b0;
		wr(5'h00, 8'h88);
		w = nw;
		slp <= 1'b1;
		pulse(16'h0001);
		repeat (20) @(posedge clk);
		chk(nw > w, 1'b1);
		chk(nf, b);
		slp <= 1'b0;
		wflush(b + 1);
		repeat (20) @(posedge clk);
		// Status flags: normal retire loads, swap keeps
		rt <= 5'h15;
		@(posedge clk);
		rt <= 5'h1A;
		@(posedge clk);
		rt <= 5'h00;
		acc(1'b0, 5'h1C, 8'h00, 4'hF);
		chk(r[2:0], 3'h5);
		// Reset cause bits and enables after resets
		wr(5'h00, 8'hF8);
		wr(5'h18, 8'h03);
		rpulse(2'h1);
		acc(1'b0, 5'h18, 8'h00, 4'hF);
		chk(r[1:0], 2'h2);
		wr(5'h18, 8'h03);
		rpulse(2'h0);
		acc(1'b0, 5'h18, 8'h00, 4'hF);
		chk(r[1:0], 2'h3);
		rc(5'h00, 8'h00);
		acc(1'b1, 5'h14, 8'h00, 4'hE);
		rc(5'h14, 8'hFF);
		stop_test();
	end
endmodule
